//--- src/tuner_powerup_dc_sequencer.sv
// Power-up sequencer, hardware/software shutdown and DC offset correction control.
// Assumes a host writes the control fields over the plain register port and drives both pins.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Two-bit threshold select picks one of four correction thresholds.
// - Two-bit speed select sets correction speed and highpass corner.
// - Speed code 00 holds the correction value and stops correcting.
// - Shutdown pin low disables everything except the reference buffer control.
// - Registers survive hardware shutdown and take effect again on exit.
// - Each shutdown bit kills one block; full off needs 0xFF, 00, 00.
// - Select low at shutdown exit: synthesiser first, then signal path.
// - Second step overrides both gain voltages and correction within 0.5 ms.
// - After correction, programmed state returns; whole sequence near 2 ms.
// - Speed 00 before exit gives one calibration, then correction stays off.
// - Select high powers all blocks at once; speed 00 never calibrates.
// - Select level matters only at shutdown exit.
// - Reference buffer output follows the reference-off bit.
module tuner_powerup_dc_sequencer
(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // External pins
  input  wire logic                 hw_shutdown_n_i,
  input  wire logic                 auto_cal_select_n_i,
  // Register port
  input  wire pwrseq_pkg::bus_req_t bus_i,
  output logic [7:0]                rdata_o,
  // Analog controls and status
  output var pwrseq_pkg::ctl_out_t  ctl_o,
  output logic                      seq_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]             shutdown;
    logic [1:0]             vco_ctl;
    logic [5:0]             dc_ctl;
    logic [3:0]             bb;
    pwrseq_pkg::seq_state_t st;
    logic                   cal_once;
    logic                   tstart;
    logic [11:0]            tload;
    logic [7:0]             rdata;
    logic                   busy;
    pwrseq_pkg::ctl_out_t   out;
  } seq_core_t;

  seq_core_t c_q;
  seq_core_t c_d;

  logic [1:0] pin_lvl;
  logic       hw_on;
  logic       cal_sel_n;
  logic       tdone;
  logic [1:0] speed_d;
  logic [1:0] mode_d;
  logic [6:0] allow;
  logic       sw_full;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and step timer

  level_sync u_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({auto_cal_select_n_i, hw_shutdown_n_i}),
    .level_o   (pin_lvl)
  );

  assign hw_on     = pin_lvl[pwrseq_pkg::SYNC_HW_BIT];
  assign cal_sel_n = pin_lvl[pwrseq_pkg::SYNC_CAL_BIT];

  step_timer u_timer
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (c_q.tstart),
    .ticks_i   (c_q.tload),
    .done_o    (tdone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Registers only change on writes, never on shutdown, so settings come back on exit
  always_comb
  begin
    c_d        = c_q;
    c_d.tstart = 1'b0;
    c_d.rdata  = 8'h00;
    speed_d    = 2'h0;
    mode_d     = 2'h0;
    allow      = 7'h00;
    sw_full    = 1'b0;

    // Register writes; unmapped offsets are ignored
    if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        pwrseq_pkg::REG_SHUTDOWN: c_d.shutdown = bus_i.wdata;
        pwrseq_pkg::REG_VCO:      c_d.vco_ctl  = bus_i.wdata[1:0];
        pwrseq_pkg::REG_DC:       c_d.dc_ctl   = bus_i.wdata[5:0];
        pwrseq_pkg::REG_BB:       c_d.bb       = bus_i.wdata[3:0];
        default:                  c_d.bb       = c_q.bb;
      endcase
    end

    // Full software shutdown seen by status
    sw_full = (c_q.shutdown == pwrseq_pkg::SD_ALL_OFF) && (c_q.vco_ctl == pwrseq_pkg::CODE_OFF)
              && (c_q.dc_ctl[pwrseq_pkg::DC_MODE_LSB +: 2] == pwrseq_pkg::CODE_OFF);

    // Reads answer next cycle; unmapped reads return zero
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        pwrseq_pkg::REG_SHUTDOWN: c_d.rdata = c_q.shutdown;
        pwrseq_pkg::REG_VCO:      c_d.rdata = {6'h00, c_q.vco_ctl};
        pwrseq_pkg::REG_DC:       c_d.rdata = {2'h0, c_q.dc_ctl};
        pwrseq_pkg::REG_STATUS:   c_d.rdata = {2'h0, sw_full, hw_on, c_q.cal_once, 1'b0, c_q.st};
        pwrseq_pkg::REG_BB:       c_d.rdata = {4'h0, c_q.bb};
        default:                  c_d.rdata = 8'h00;
      endcase
    end

    // Sequencer; the select pin is consulted only when leaving OFF
    unique case (c_q.st)
      pwrseq_pkg::ST_OFF:
      begin
        if (hw_on)
        begin
          if (!cal_sel_n)
          begin
            c_d.st     = pwrseq_pkg::ST_PLL;
            c_d.tstart = 1'b1;
            c_d.tload  = 12'(pwrseq_pkg::PLL_SETTLE_TICKS);
          end
          else
            c_d.st = pwrseq_pkg::ST_ACTIVE;
        end
      end
      pwrseq_pkg::ST_PLL:
      begin
        if (!hw_on)
          c_d.st = pwrseq_pkg::ST_OFF;
        else if (tdone)
        begin
          c_d.st     = pwrseq_pkg::ST_CAL;
          c_d.tstart = 1'b1;
          c_d.tload  = 12'(pwrseq_pkg::CAL_TIME_TICKS);
        end
      end
      pwrseq_pkg::ST_CAL:
      begin
        if (!hw_on)
          c_d.st = pwrseq_pkg::ST_OFF;
        else if (tdone)
        begin
          c_d.st       = pwrseq_pkg::ST_ACTIVE;
          c_d.cal_once = 1'b1;
        end
      end
      pwrseq_pkg::ST_ACTIVE:
      begin
        if (!hw_on)
          c_d.st = pwrseq_pkg::ST_OFF;
      end
    endcase

    // Outputs follow the next state so they line up with the state register
    speed_d = c_d.dc_ctl[pwrseq_pkg::DC_SPEED_LSB +: 2];
    mode_d  = c_d.dc_ctl[pwrseq_pkg::DC_MODE_LSB +: 2];
    unique case (c_d.st)
      pwrseq_pkg::ST_OFF:    allow = 7'h00;
      pwrseq_pkg::ST_PLL:    allow = pwrseq_pkg::SYNTH_MASK;
      pwrseq_pkg::ST_CAL:    allow = pwrseq_pkg::ALL_MASK;
      pwrseq_pkg::ST_ACTIVE: allow = pwrseq_pkg::ALL_MASK;
    endcase
    c_d.busy                     = (c_d.st == pwrseq_pkg::ST_PLL) || (c_d.st == pwrseq_pkg::ST_CAL);
    c_d.out.block_en             = ~c_d.shutdown[6:0] & allow;
    c_d.out.vco_mode             = (c_d.st == pwrseq_pkg::ST_OFF) ? pwrseq_pkg::CODE_OFF : c_d.vco_ctl;
    c_d.out.offset_mode_sel      = (c_d.st == pwrseq_pkg::ST_OFF) ? pwrseq_pkg::CODE_OFF : mode_d;
    c_d.out.offset_speed_sel     = speed_d;
    c_d.out.offset_threshold_sel = c_d.dc_ctl[pwrseq_pkg::DC_THRESH_LSB +: 2];
    c_d.out.gain_override        = (c_d.st == pwrseq_pkg::ST_CAL);
    c_d.out.corr_fast            = (c_d.st == pwrseq_pkg::ST_CAL);
    // Hold code freezes the correction value, even right after a one-time calibration
    c_d.out.corr_run             = (c_d.st == pwrseq_pkg::ST_CAL)
                                   || ((c_d.st == pwrseq_pkg::ST_ACTIVE) && (speed_d != pwrseq_pkg::CODE_OFF)
                                       && (mode_d != pwrseq_pkg::CODE_OFF));
    // Reference buffer ignores the shutdown pin on purpose: the demodulator may still need it
    c_d.out.ref_clock_out_en     = ~c_d.shutdown[pwrseq_pkg::SD_REF_BIT];
    c_d.out.bb_cutoff_code       = c_d.bb;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      c_q          <= '0;
      c_q.shutdown <= pwrseq_pkg::SHUTDOWN_RST;
      c_q.vco_ctl  <= pwrseq_pkg::VCO_RST;
      c_q.dc_ctl   <= pwrseq_pkg::DC_RST;
      c_q.bb       <= pwrseq_pkg::BB_RST;
      c_q.st       <= pwrseq_pkg::ST_OFF;
      c_q.out.ref_clock_out_en <= 1'b1;
    end
    else
      c_q <= c_d;
  end

  assign rdata_o    = c_q.rdata;
  assign ctl_o      = c_q.out;
  assign seq_busy_o = c_q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int CAL_LIMIT = pwrseq_pkg::CAL_LIMIT_CYCLES;
  localparam int CAL_MIN   = pwrseq_pkg::CAL_TIME_TICKS * pwrseq_pkg::TICK_CYCLES;

  logic [13:0] cal_cyc_q;

  // Cycles spent in the calibration step, for the time bound
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cal_cyc_q <= 14'h0000;
    else if (c_q.st == pwrseq_pkg::ST_CAL)
      cal_cyc_q <= cal_cyc_q + 14'h0001;
    else
      cal_cyc_q <= 14'h0000;
  end

  sequence exit_with_cal_s;
    (c_q.st == pwrseq_pkg::ST_OFF) && hw_on && !cal_sel_n;
  endsequence

  sequence exit_direct_s;
    (c_q.st == pwrseq_pkg::ST_OFF) && hw_on && cal_sel_n;
  endsequence

  // Calibration step handing over to normal operation
  sequence cal_done_s;
    (c_q.st == pwrseq_pkg::ST_CAL) ##1 (c_q.st == pwrseq_pkg::ST_ACTIVE);
  endsequence

  thresh_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bus_i.wr && (bus_i.addr == pwrseq_pkg::REG_DC) |=> ctl_o.offset_threshold_sel == $past(bus_i.wdata[1:0]))
    else $error("threshold select did not follow write");

  speed_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ctl_o.offset_speed_sel == c_q.dc_ctl[pwrseq_pkg::DC_SPEED_LSB +: 2])
    else $error("speed select mismatch");

  hold_stops_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.st == pwrseq_pkg::ST_ACTIVE) && (ctl_o.offset_speed_sel == 2'h0) |-> !ctl_o.corr_run)
    else $error("correction runs in hold");

  hw_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !hw_on |=> (ctl_o.block_en == 7'h00) && !ctl_o.gain_override && !ctl_o.corr_run)
    else $error("blocks powered during hardware shutdown");

  regs_kept_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !hw_on && !bus_i.wr |=> $stable(c_q.dc_ctl) && $stable(c_q.shutdown))
    else $error("register lost in shutdown");

  sw_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.shutdown == 8'hFF) |-> (ctl_o.block_en == 7'h00) && !ctl_o.ref_clock_out_en)
    else $error("block on with all shutdown bits set");

  seq_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exit_with_cal_s |=> (c_q.st == pwrseq_pkg::ST_PLL) && (ctl_o.block_en == (~c_q.shutdown[6:0] & 7'h01)))
    else $error("sequence did not start with synthesiser");

  cal_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cal_cyc_q <= 14'(CAL_LIMIT))
    else $error("calibration step too long");

  gain_override_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.st == pwrseq_pkg::ST_CAL) |-> ctl_o.gain_override && ctl_o.corr_run && ctl_o.corr_fast)
    else $error("no override in calibration step");

  state_restore_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(c_q.st == pwrseq_pkg::ST_CAL) && hw_on |-> (c_q.st == pwrseq_pkg::ST_ACTIVE) && !ctl_o.gain_override
      && (ctl_o.corr_run == (ctl_o.offset_speed_sel != 2'h0 && ctl_o.offset_mode_sel != 2'h0)))
    else $error("programmed state not restored");

  direct_up_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exit_direct_s |=> (c_q.st == pwrseq_pkg::ST_ACTIVE) && !ctl_o.corr_fast)
    else $error("direct power-up wrong");

  ref_buf_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ctl_o.ref_clock_out_en == !c_q.shutdown[7])
    else $error("reference buffer enable wrong");

  // Remaining step checks; the length bound catches a timer that ends the calibration step early
  busy_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_busy_o == ((c_q.st == pwrseq_pkg::ST_PLL) || (c_q.st == pwrseq_pkg::ST_CAL)))
    else $error("busy flag does not match sequencer step");

  off_modes_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.st == pwrseq_pkg::ST_OFF) |-> (ctl_o.vco_mode == 2'h0) && (ctl_o.offset_mode_sel == 2'h0) && !seq_busy_o)
    else $error("synthesiser or correction mode live in shutdown");

  synth_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.st == pwrseq_pkg::ST_PLL) |-> (ctl_o.block_en == (~c_q.shutdown[6:0] & pwrseq_pkg::SYNTH_MASK))
      && !ctl_o.corr_run && !ctl_o.gain_override)
    else $error("signal path powered during synthesiser step");

  vco_resume_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.st != pwrseq_pkg::ST_OFF) |-> (ctl_o.vco_mode == c_q.vco_ctl))
    else $error("programmed synthesiser mode not applied");

  select_ignored_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (c_q.st == pwrseq_pkg::ST_ACTIVE) && hw_on |=> (c_q.st == pwrseq_pkg::ST_ACTIVE))
    else $error("select pin acted outside shutdown exit");

  cal_mark_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cal_done_s |-> c_q.cal_once && !ctl_o.corr_fast && !seq_busy_o)
    else $error("one-time calibration not recorded");

  cal_length_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cal_done_s |-> (cal_cyc_q >= 14'(CAL_MIN)))
    else $error("calibration step ended early");

  ref_hw_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !hw_on && !c_q.shutdown[pwrseq_pkg::SD_REF_BIT] |-> ctl_o.ref_clock_out_en)
    else $error("reference buffer lost in hardware shutdown");

endmodule

`default_nettype wire

//--- src/pwrseq_pkg.sv
// Shared constants and carrier types for the tuner power-up and DC offset sequencer.
// Assumes one 20 MHz reference clock and an 8-bit plain register port.
package pwrseq_pkg;

  // Clock and sequencer timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int TICK_NS          = 1000;
  localparam int TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  localparam int PLL_SETTLE_US    = 1500;
  localparam int CAL_TIME_US      = 450;
  localparam int CAL_LIMIT_US     = 500;
  localparam int PLL_SETTLE_TICKS = PLL_SETTLE_US * 1000 / TICK_NS;
  localparam int CAL_TIME_TICKS   = CAL_TIME_US * 1000 / TICK_NS;
  localparam int CAL_LIMIT_CYCLES = CAL_LIMIT_US * 1000 / CLK_PERIOD_NS;

  // Widths
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;
  localparam int CNT_W    = 12;
  localparam int DIV_W    = 5;
  localparam int SYNC_W   = 2;
  localparam int BLOCKS   = 7;

  // Register offsets
  localparam logic [3:0] REG_SHUTDOWN = 4'h0;
  localparam logic [3:0] REG_VCO      = 4'h1;
  localparam logic [3:0] REG_DC       = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_BB       = 4'hA;

  // Field positions
  localparam int SD_REF_BIT     = 7;
  localparam int DC_THRESH_LSB  = 0;
  localparam int DC_SPEED_LSB   = 2;
  localparam int DC_MODE_LSB    = 4;
  localparam int SYNC_HW_BIT    = 0;
  localparam int SYNC_CAL_BIT   = 1;

  // Reset values and special codes
  localparam logic [7:0] SHUTDOWN_RST = 8'h00;
  localparam logic [1:0] VCO_RST      = 2'h0;
  localparam logic [5:0] DC_RST       = 6'h00;
  localparam logic [3:0] BB_RST       = 4'h0;
  localparam logic [7:0] SD_ALL_OFF   = 8'hFF;
  localparam logic [1:0] CODE_OFF     = 2'h0;
  localparam logic [6:0] SYNTH_MASK   = 7'h01;
  localparam logic [6:0] ALL_MASK     = 7'h7F;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_PLL    = 2'b01,
    ST_CAL    = 2'b10,
    ST_ACTIVE = 2'b11
  } seq_state_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // Controls toward the analog blocks
  typedef struct packed {
    logic [6:0] block_en;
    logic [1:0] vco_mode;
    logic [1:0] offset_mode_sel;
    logic [1:0] offset_speed_sel;
    logic [1:0] offset_threshold_sel;
    logic       corr_run;
    logic       corr_fast;
    logic       gain_override;
    logic       ref_clock_out_en;
    logic [3:0] bb_cutoff_code;
  } ctl_out_t;

endpackage

//--- src/level_sync.sv
// Three-stage synchroniser for the external shutdown and calibration-select pins.
// Assumes pins are asynchronous to clk_sys_i; a change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module level_sync
(
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_n_i,
  // Pins and filtered levels
  input  wire logic [pwrseq_pkg::SYNC_W-1:0] pin_i,
  output logic      [pwrseq_pkg::SYNC_W-1:0] level_o
);

  typedef struct packed {
    logic [pwrseq_pkg::SYNC_W-1:0] ff1;
    logic [pwrseq_pkg::SYNC_W-1:0] ff2;
    logic [pwrseq_pkg::SYNC_W-1:0] ff3;
    logic [pwrseq_pkg::SYNC_W-1:0] lvl;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Level follows only where stages two and three agree, so a late glitch never lands
  always_comb
  begin
    s_d     = s_q;
    s_d.ff1 = pin_i;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    s_d.lvl = (s_q.ff2 & s_q.ff3) | (s_q.lvl & (s_q.ff2 | s_q.ff3));
  end

  // Reset reads as shutdown asserted
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level_o = s_q.lvl;

endmodule

`default_nettype wire

//--- src/step_timer.sv
// Step timer: a 1 us tick divider and a down counter of ticks.
// Assumes start_i is a one-cycle pulse; a new start reloads a running count.
`timescale 1ns/1ps
`default_nettype none

module step_timer
(
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_n_i,
  // Control
  input  wire logic                         start_i,
  input  wire logic [pwrseq_pkg::CNT_W-1:0] ticks_i,
  output logic                              done_o
);

  localparam logic [pwrseq_pkg::DIV_W-1:0] DIV_LAST = pwrseq_pkg::DIV_W'(pwrseq_pkg::TICK_CYCLES - 1);

  typedef struct packed {
    logic [pwrseq_pkg::DIV_W-1:0] div;
    logic [pwrseq_pkg::CNT_W-1:0] cnt;
    logic                         busy;
    logic                         done;
  } timer_state_t;

  timer_state_t t_q;
  timer_state_t t_d;

  // Divider restarts with each start so every step lasts whole ticks
  always_comb
  begin
    t_d      = t_q;
    t_d.done = 1'b0;
    if (start_i)
    begin
      t_d.div  = '0;
      t_d.cnt  = ticks_i;
      t_d.busy = 1'b1;
    end
    else if (t_q.busy)
    begin
      if (t_q.div == DIV_LAST)
      begin
        t_d.div = '0;
        if (t_q.cnt <= 12'h001)
        begin
          t_d.busy = 1'b0;
          t_d.done = 1'b1;
        end
        else
          t_d.cnt = t_q.cnt - 12'h001;
      end
      else
        t_d.div = t_q.div + 5'h01;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign done_o = t_q.done;

endmodule

`default_nettype wire

//--- verif/tuner_host_model.sv
// Host model: drives the shutdown pins and the plain register port of the sequencer.
// Assumes one clock shared with the sequencer; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module tuner_host_model
(
  // Clock
  input  wire logic                clk_sys_i,
  // Register port and pins
  input  wire logic [7:0]          rdata_i,
  output var pwrseq_pkg::bus_req_t bus_o,
  output logic                     hw_shutdown_n_o,
  output logic                     auto_cal_select_n_o
);
  // Idle levels from time zero: shutdown held, auto calibration off
  initial
  begin
    bus_o               = '0;
    hw_shutdown_n_o     = 1'h0;
    auto_cal_select_n_o = 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus_o.addr  <= a;
    bus_o.wdata <= d;
    bus_o.wr    <= 1'h1;
    @(posedge clk_sys_i);
    bus_o.wr    <= 1'h0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    bus_o.addr <= a;
    bus_o.rd   <= 1'h1;
    @(posedge clk_sys_i);
    bus_o.rd   <= 1'h0;
    @(negedge clk_sys_i);
    d = rdata_i;
  endtask

  // Both pins change together after an edge
  task automatic pins(input logic sd_n, input logic sel_n);
    @(posedge clk_sys_i);
    hw_shutdown_n_o     <= sd_n;
    auto_cal_select_n_o <= sel_n;
  endtask

  // Factory code moved by a signed offset; staying in -6..+2 is up to the caller
  task automatic load_cutoff(input logic [3:0] factory, input int off);
    wr(4'hA, {4'h0, 4'(int'(factory) + off)});
  endtask

  // Fresh calibration after a change: pass through shutdown with auto calibration selected
  task automatic recal();
    pins(1'h0, 1'h0);
    repeat (8) @(posedge clk_sys_i);
    pins(1'h1, 1'h0);
  endtask
endmodule

`default_nettype wire

//--- verif/tuner_powerup_dc_sequencer_bench.sv
// Self-checking bench: the host model drives the sequencer, a bench model predicts its controls.
// Assumes step lengths from the package constants and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tuner_powerup_dc_sequencer_bench;
  logic                 clk_sys_i;
  logic                 rst_n_i;
  logic                 hw_shutdown_n;
  logic                 auto_cal_select_n;
  pwrseq_pkg::bus_req_t bus;
  logic [7:0]           rdata;
  pwrseq_pkg::ctl_out_t ctl;
  logic                 busy;
  logic [7:0]           regs [16];
  logic [7:0]           v;
  int                   err_total;
  int                   cmp_count;
  int                   t_pll;
  int                   t_cal;

  // Device and host
  tuner_powerup_dc_sequencer i_tuner_powerup_dc_sequencer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .hw_shutdown_n_i(hw_shutdown_n), .auto_cal_select_n_i(auto_cal_select_n), .bus_i(bus),
    .rdata_o(rdata), .ctl_o(ctl), .seq_busy_o(busy));
  tuner_host_model i_tuner_host_model (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .bus_o(bus),
    .hw_shutdown_n_o(hw_shutdown_n), .auto_cal_select_n_o(auto_cal_select_n));

  // 20 MHz clock
  initial
  begin
    clk_sys_i = 1'h0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected controls in state st: 0 off, 1 synth, 2 calibrate, 3 active
  function automatic pwrseq_pkg::ctl_out_t exp_ctl(input int st);
    pwrseq_pkg::ctl_out_t e;
    e = '0;
    e.ref_clock_out_en     = ~regs[0][7];
    e.offset_threshold_sel = regs[2][1:0];
    e.offset_speed_sel     = regs[2][3:2];
    e.bb_cutoff_code       = regs[10][3:0];
    if (st != 0)
    begin
      e.vco_mode        = regs[1][1:0];
      e.offset_mode_sel = regs[2][5:4];
      e.block_en        = ~regs[0][6:0];
    end
    if (st == 1)
      e.block_en = e.block_en & 7'h01;
    if (st == 2)
      {e.gain_override, e.corr_run, e.corr_fast} = 3'h7;
    if (st == 3)
      e.corr_run = (regs[2][3:2] != 2'h0) && (regs[2][5:4] != 2'h0);
    return e;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Writes keep the bench copy in step; the status register is read-only
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    i_tuner_host_model.wr(a, d);
    case (a)
      4'h0: regs[0] = d;
      4'h1: regs[1] = d & 8'h03;
      4'h2: regs[2] = d & 8'h3F;
      4'hA: regs[10] = d & 8'h0F;
      default: ;
    endcase
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    i_tuner_host_model.rd(a, v);
    check(32'(v), 32'(e));
  endtask

  // Bounded wait until the controls match state st; n gives the cycles taken
  task automatic wait_for(input int st, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (ctl !== exp_ctl(st) && n < lim);
    check(32'(ctl), 32'(exp_ctl(st)));
    check(32'(busy), 32'(st == 1 || st == 2));
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog: one full sequence is about 39000 cycles
  initial
  begin
    #(50 * 60000);
    err_total++;
    $display("watchdog expired at %0t ns", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int n;
    int d;
    rst_n_i = 1'h0;
    err_total = 0;
    cmp_count = 0;
    foreach (regs[i]) regs[i] = 8'h00;
    void'($urandom(32'hD348));
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    wait_for(0, 1, n);
    $display("test reset done");

    // Random fields while held in shutdown; status and unmapped writes are ignored
    repeat (4)
    begin
      reg_wr(4'h0, 8'($urandom));
      reg_wr(4'h1, 8'($urandom));
      reg_wr(4'h2, 8'($urandom));
      reg_wr(4'h3, 8'($urandom));
      reg_wr(4'h5, 8'($urandom));
      reg_rd(4'h0, regs[0]);
      reg_rd(4'h2, regs[2]);
      reg_rd(4'h5, 8'h00);
      wait_for(0, 1, n);
    end
    $display("test registers done");

    // Every documented cutoff offset applied to a factory code
    for (int off = -6; off <= 2; off++)
    begin
      i_tuner_host_model.load_cutoff(4'h8, off);
      regs[10] = 8'(8 + off);
      reg_rd(4'hA, regs[10]);
    end
    $display("test cutoff done");

    // Exit with auto calibration deselected: all blocks at once, hold means no calibration
    reg_wr(4'h0, 8'h00);
    reg_wr(4'h1, 8'h02);
    reg_wr(4'h2, 8'h10 | (8'($urandom) & 8'h03));
    i_tuner_host_model.pins(1'h1, 1'h1);
    wait_for(3, 10, n);
    reg_rd(4'h3, 8'h13);
    i_tuner_host_model.pins(1'h1, 1'h0);
    repeat (10) @(negedge clk_sys_i);
    wait_for(3, 1, n);
    reg_wr(4'h2, 8'h14);
    wait_for(3, 2, n);
    reg_wr(4'h2, 8'h10);
    wait_for(3, 2, n);
    repeat (4)
    begin
      reg_wr(4'h0, {1'h0, 7'($urandom)});
      wait_for(3, 2, n);
    end
    reg_wr(4'h0, 8'hFF);
    reg_wr(4'h1, 8'h00);
    reg_wr(4'h2, 8'h00);
    wait_for(3, 2, n);
    reg_rd(4'h3, 8'h33);
    $display("test select high done");

    // Shutdown in the synth step aborts at once and keeps the settings
    reg_wr(4'h0, 8'h00);
    reg_wr(4'h1, 8'h01);
    reg_wr(4'h2, 8'h10 | (8'($urandom) & 8'h03));
    i_tuner_host_model.pins(1'h0, 1'h0);
    wait_for(0, 8, n);
    i_tuner_host_model.pins(1'h1, 1'h0);
    wait_for(1, 8, n);
    repeat (100) @(negedge clk_sys_i);
    i_tuner_host_model.pins(1'h0, 1'h0);
    wait_for(0, 8, n);
    reg_rd(4'h2, regs[2]);
    $display("test abort done");

    // Full sequence with hold selected: one calibration, then correction stays off
    i_tuner_host_model.recal();
    wait_for(1, 10, n);
    wait_for(2, 32000, t_pll);
    wait_for(3, 10500, t_cal);
    d = t_pll - pwrseq_pkg::PLL_SETTLE_TICKS * pwrseq_pkg::TICK_CYCLES;
    check(32'(d >= -8 && d <= 8), 32'h1);
    check(32'(t_cal <= pwrseq_pkg::CAL_LIMIT_CYCLES), 32'h1);
    check(32'(t_pll + t_cal >= 36000 && t_pll + t_cal <= 44000), 32'h1);
    reg_rd(4'h3, 8'h1B);
    $display("test calibration done");
    stop_test();
  end
endmodule

`default_nettype wire
